// ### common/usb_interface_manager_pkg.sv
package usb_interface_manager_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_SOFT_RESET = 8'h00;
  localparam logic [7:0] OFF_CONTROL = 8'h04;
  localparam logic [7:0] OFF_DEVICE_ADDRESS = 8'h08;
  localparam logic [7:0] OFF_FUNCTION = 8'h0c;
  localparam logic [7:0] OFF_OTG_CONTROL = 8'h10;
  localparam logic [7:0] OFF_OTG_STATUS = 8'h14;
  localparam logic [7:0] OFF_SERIAL = 8'h18;
  localparam logic [7:0] OFF_FLAGS = 8'h1c;
  localparam logic [7:0] OFF_HOLD_SELECT = 8'h20;
  localparam logic [7:0] OFF_PORT_MASKS = 8'h24;
  localparam logic [7:0] OFF_FRAME_COUNTER = 8'h28;
  localparam logic [7:0] OFF_PACKET_ID = 8'h2c;
  localparam logic [7:0] OFF_ENDPOINT = 8'h30;
  localparam logic [7:0] OFF_ENDPOINT_MARK = 8'h34;
  localparam logic [7:0] OFF_OTG_FLAG_MASK = 8'h38;
  localparam logic [7:0] OFF_POWER_SIGNAL = 8'h3c;
  localparam logic [7:0] OFF_PHY_CONTROL = 8'h40;

  // ----------------------------------------------------------------
  // Field positions, writable masks and reset values
  // ----------------------------------------------------------------
  localparam int CTL_TOKEN_PROCESSING = 0;
  localparam int CTL_TOKEN_CHECKING = 1;
  localparam int CTL_LINE_DECODE = 2;
  localparam int CTL_IF_TIMING = 4;
  localparam int CTL_POWER_SIGNALLING = 5;
  localparam int CTL_FRAME_START_AS_TOKEN = 6;
  localparam int CTL_EVENT_ACK_MODE = 7;
  localparam logic [7:0] CTL_WRITE_MASK = 8'hf7;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam int ADDR_W = 7;
  localparam int FUNC_OPMODE_LSB = 2;
  localparam int FUNC_TERM_SELECT = 1;
  localparam int FUNC_XCVR_SELECT = 0;
  localparam logic [4:0] FUNC_RESET = 5'h07;
  localparam logic [7:0] OTG_CTRL_WRITE_MASK = 8'hdf;
  localparam logic [7:0] OTG_CTRL_RESET = 8'h00;
  localparam int SERIAL_RX_LSB = 4;
  localparam int SERIAL_TX_SE0 = 3;
  localparam int SERIAL_TX_DATA = 2;
  localparam int SERIAL_TX_EN_LOW = 1;
  localparam int SERIAL_SPEED_MODE = 0;
  localparam logic [3:0] SERIAL_RESET = 4'h2;
  localparam int NUM_FLAGS = 7;
  localparam int FLAG_NEW_TOKEN = 6;
  localparam int FLAG_SE0 = 5;
  localparam int FLAG_K = 4;
  localparam int FLAG_J = 3;
  localparam int FLAG_DATA_CHECK_FAIL = 2;
  localparam int FLAG_RX_ACTIVE = 1;
  localparam int FLAG_RX_ERROR = 0;
  localparam int NUM_PORT_LINES = 4;
  localparam int PORT_MASK_W = 8;

  // ----------------------------------------------------------------
  // Line states and packet coding
  // ----------------------------------------------------------------
  localparam logic [1:0] LINE_SE0 = 2'h0;
  localparam logic [1:0] LINE_J = 2'h1;
  localparam logic [1:0] LINE_K = 2'h2;
  localparam logic [1:0] PID_KIND_TOKEN = 2'h1;
  localparam logic [1:0] PID_KIND_DATA = 2'h3;
  localparam logic [3:0] PID_FRAME_START = 4'h5;
  localparam logic [2:0] TOKEN_BYTES = 3'h3;
  localparam logic [4:0] CRC5_POLY = 5'h05;
  localparam logic [4:0] CRC5_INIT = 5'h1f;
  localparam logic [4:0] CRC5_RESIDUAL = 5'h0c;
  localparam logic [15:0] CRC16_POLY = 16'h8005;
  localparam logic [15:0] CRC16_INIT = 16'hffff;
  localparam logic [15:0] CRC16_RESIDUAL = 16'h800d;

  // Register access request from the processor side
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } cfg_req_t;

  // Status coming back from the transceiver
  typedef struct packed {
    logic [1:0] line_state;
    logic rx_active;
    logic rx_valid;
    logic rx_error;
    logic [7:0] rx_data;
    logic [5:0] otg_status;
    logic [2:0] serial_rx;
  } phy_status_t;

  // Control driven to the transceiver
  typedef struct packed {
    logic [2:0] op_mode;
    logic term_select;
    logic xcvr_select;
    logic [7:0] otg_control;
    logic [3:0] serial_tx;
  } phy_ctrl_t;

endpackage : usb_interface_manager_pkg

// ### dv/usb_interface_manager_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module usb_interface_manager_tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  usb_interface_manager_pkg::cfg_req_t req = '0;
  usb_interface_manager_pkg::phy_status_t st;
  usb_interface_manager_pkg::phy_ctrl_t ctrl;
  logic [31:0] rdata, v, sh[6];
  logic rvalid;
  logic [2:0] modes;
  logic [3:0] ports;
  logic [8:0] s = '0;
  logic [7:0] ra[6] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h20};
  logic [31:0] rm[6] = '{32'hf7, 32'h7f, 32'h1f, 32'hdf, 32'h0f, 32'h7f};
  logic [31:0] rv[6] = '{32'h0, 32'h0, 32'h7, 32'h0, 32'h2, 32'h0};
  logic [6:0] a;
  logic [23:0] sof;
  int err_count = 0;
  int compares = 0;

  always #2 ref_clk = ~ref_clk;

  usb_interface_manager u_dut (.ref_clk(ref_clk), .rst(rst), .cfg_req(req), .cfg_rdata(rdata),
    .cfg_rvalid(rvalid), .phy_status(st), .phy_ctrl(ctrl), .timing_modes(modes),
    .port_lines(ports));
  usb_phy_model u_phy (.ref_clk(ref_clk), .st(st));

  // ---------------------------------------------
  // Bus tasks and checks
  // ---------------------------------------------
  task automatic stop_test();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s exp %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Whole words only; one idle edge after each so strobes never retoggle
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    req <= '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: d};
    @(posedge ref_clk);
    req.wr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  task automatic rc(input logic [7:0] ad, input logic [31:0] exp);
    int n;
    req <= '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 32'h0};
    @(posedge ref_clk);
    req.rd <= 1'b0;
    for (n = 0; n < 4; n++) begin
      #1;
      if (rvalid === 1'b1) break;
      @(posedge ref_clk);
    end
    if (n == 4) begin
      err_count++;
      stop_test();
    end
    chk($sformatf("reg %h", ad), rdata, exp);
    @(posedge ref_clk);
  endtask : rc

  task automatic check_resets();
    for (int j = 0; j < 6; j++) rc(ra[j], rv[j] | (j == 4 ? {25'h0, s[8:6], 4'h0} : 32'h0));
  endtask : check_resets

  // Token with correct CRC5, endpoint zero, OUT PID with its check nibble
  function automatic logic [23:0] tok(input logic [6:0] ad);
    logic [4:0] c;
    c = 5'h1f;
    for (int i = 0; i < 11; i++) c = {c[3:0], 1'b0} ^ (((i < 7 ? ad[i] : 1'b0) ^ c[4]) ? 5'h05 : 5'h00);
    c = ~c;
    return {c[0], c[1], c[2], c[3], c[4], 3'h0, 1'b0, ad, 8'he1};
  endfunction : tok

  task automatic pkt_flags(input logic [23:0] p, input logic [31:0] exp);
    u_phy.send(p);
    rc(8'h1c, exp);
  endtask : pkt_flags

  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    v = $urandom(91);
    sh = rv;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    check_resets();
    rc(8'h44, 32'h0);
    s = 9'($urandom);
    u_phy.set_status(2'h1, s[5:0], s[8:6]);
    repeat (4) @(posedge ref_clk);
    rc(8'h14, {26'h0, s[5:0]});
    for (int k = 0; k < 30; k++) begin
      v = $urandom;
      wr(ra[k % 6], v);
      sh[k % 6] = v & rm[k % 6];
      rc(ra[k % 6], sh[k % 6] | (k % 6 == 4 ? {25'h0, s[8:6], 4'h0} : 32'h0));
      chk("phy_ctrl", {15'h0, ctrl}, {15'h0, sh[2][4:0], sh[3][7:0], sh[4][3:0]});
      chk("timing", {29'h0, modes}, {29'h0, sh[0][7], sh[0][5], sh[0][4]});
    end
    wr(8'h00, $urandom);
    check_resets();
    // Decoder on, nothing held: J, then hold J across the change to K
    wr(8'h04, 32'h07);
    repeat (4) @(posedge ref_clk);
    rc(8'h1c, 32'h08);
    wr(8'h20, 32'h08);
    u_phy.set_status(2'h2, s[5:0], s[8:6]);
    repeat (4) @(posedge ref_clk);
    rc(8'h1c, 32'h18);
    wr(8'h1c, 32'h08);
    rc(8'h1c, 32'h10);
    wr(8'h20, 32'h00);
    wr(8'h24, 32'h00000010);
    @(posedge ref_clk);  // Port lines are registered one edge behind the mask write
    chk("ports", {28'h0, ports}, 32'h1);
    a = 7'($urandom_range(1, 127));
    wr(8'h08, {25'h0, a});
    pkt_flags(tok(a ^ 7'h01), 32'h10);
    pkt_flags(tok(a), 32'h50);
    pkt_flags({8'h00, 8'h01, 8'hc3}, 32'h14);
    pkt_flags({8'h00, 8'h00, 8'hc3}, 32'h10);
    wr(8'h20, 32'h40);
    pkt_flags(tok(a), 32'h50);
    pkt_flags({8'h00, 8'h01, 8'hc3}, 32'h54);
    rc(8'h2c, 32'h1);
    rc(8'h30, 32'h10);
    // Frame start token: refused until its mode bit is on, then taken with PID 5 and endpoint zero
    sof = tok(a);
    sof[7:0] = 8'ha5;
    wr(8'h20, 32'h00);
    pkt_flags(sof, 32'h10);
    wr(8'h04, 32'h47);
    pkt_flags(sof, 32'h50);
    rc(8'h2c, 32'h5);
    rc(8'h30, 32'h0);
    stop_test();
  end
endmodule : usb_interface_manager_tb_top

`default_nettype wire

// ### dv/usb_phy_model.sv
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------
// Transceiver model: receive packets, line and session status
// ---------------------------------------------
module usb_phy_model (
  input wire logic ref_clk,
  output var usb_interface_manager_pkg::phy_status_t st
);
  initial st = '0;

  // Status changes land just after an edge, as a real PHY would
  task automatic set_status(input logic [1:0] ls, input logic [5:0] otg, input logic [2:0] srx);
    @(posedge ref_clk);
    st.line_state <= ls;
    st.otg_status <= otg;
    st.serial_rx <= srx;
  endtask : set_status

  // Three bytes, one valid cycle each with gaps, so synchronisers count one per byte
  task automatic send(input logic [23:0] pkt);
    @(posedge ref_clk);
    st.rx_active <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      st.rx_valid <= 1'b1;
      st.rx_data <= pkt[8*i +: 8];
      @(posedge ref_clk);
      st.rx_valid <= 1'b0;
      st.rx_data <= ~pkt[8*i +: 8];  // Stale byte never reused
    end
    @(posedge ref_clk);
    st.rx_active <= 1'b0;
    repeat (5) @(posedge ref_clk);
  endtask : send
endmodule : usb_phy_model

`default_nettype wire

// ### verilog/usb_interface_manager.sv
`timescale 1ns/1ps
`default_nettype none

module usb_interface_manager (
  input wire logic ref_clk,
  input wire logic rst,
  input wire usb_interface_manager_pkg::cfg_req_t cfg_req,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire usb_interface_manager_pkg::phy_status_t phy_status,
  output usb_interface_manager_pkg::phy_ctrl_t phy_ctrl,
  output logic [2:0] timing_modes,
  output logic [usb_interface_manager_pkg::NUM_PORT_LINES-1:0] port_lines
);

  // ----------------------------------------------------------------
  // Input synchronisers and soft reset
  // ----------------------------------------------------------------
  usb_interface_manager_pkg::phy_status_t status_meta;
  usb_interface_manager_pkg::phy_status_t status_sync;
  logic soft_clr;
  logic state_rst;
  // Transceiver status is foreign to ref_clk; two flops before any use
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status_meta <= '0;
      status_sync <= '0;
    end else begin
      status_meta <= phy_status;
      status_sync <= status_meta;
    end
  end

  // Write of any value to offset zero clears state one cycle later
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      soft_clr <= 1'b0;
    end else begin
      soft_clr <= cfg_req.wr && cfg_req.addr == usb_interface_manager_pkg::OFF_SOFT_RESET;
    end
  end

  assign state_rst = rst | soft_clr;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [7:0] control;
  logic [usb_interface_manager_pkg::ADDR_W-1:0] dev_addr;
  logic [4:0] func_ctrl;
  logic [7:0] otg_ctrl;
  logic [3:0] serial_ctrl;
  logic [usb_interface_manager_pkg::NUM_FLAGS-1:0] hold_sel;
  logic [31:0] port_masks;
  logic wr_control;
  logic wr_addr;
  logic wr_func;
  logic wr_flags;
  assign wr_control = cfg_req.wr && cfg_req.addr == usb_interface_manager_pkg::OFF_CONTROL;
  assign wr_addr = cfg_req.wr && cfg_req.addr == usb_interface_manager_pkg::OFF_DEVICE_ADDRESS;
  assign wr_func = cfg_req.wr && cfg_req.addr == usb_interface_manager_pkg::OFF_FUNCTION;
  assign wr_flags = cfg_req.wr && cfg_req.addr == usb_interface_manager_pkg::OFF_FLAGS;

  // Writable fields only; reserved and read-only bits are dropped
  always_ff @(posedge ref_clk) begin
    if (state_rst) begin
      control <= usb_interface_manager_pkg::CTL_RESET;
      dev_addr <= '0;
      func_ctrl <= usb_interface_manager_pkg::FUNC_RESET;
      otg_ctrl <= usb_interface_manager_pkg::OTG_CTRL_RESET;
      serial_ctrl <= usb_interface_manager_pkg::SERIAL_RESET;
      hold_sel <= '0;
      port_masks <= '0;
    end else if (cfg_req.wr) begin
      unique case (cfg_req.addr)
        usb_interface_manager_pkg::OFF_CONTROL: begin
          control <= cfg_req.wdata[7:0] & usb_interface_manager_pkg::CTL_WRITE_MASK;
        end
        usb_interface_manager_pkg::OFF_DEVICE_ADDRESS: begin
          dev_addr <= cfg_req.wdata[usb_interface_manager_pkg::ADDR_W-1:0];
        end
        usb_interface_manager_pkg::OFF_FUNCTION: begin
          func_ctrl <= cfg_req.wdata[4:0];
        end
        usb_interface_manager_pkg::OFF_OTG_CONTROL: begin
          otg_ctrl <= cfg_req.wdata[7:0] & usb_interface_manager_pkg::OTG_CTRL_WRITE_MASK;
        end
        usb_interface_manager_pkg::OFF_SERIAL: begin
          serial_ctrl <= cfg_req.wdata[3:0];
        end
        usb_interface_manager_pkg::OFF_HOLD_SELECT: begin
          hold_sel <= cfg_req.wdata[usb_interface_manager_pkg::NUM_FLAGS-1:0];
        end
        usb_interface_manager_pkg::OFF_PORT_MASKS: begin
          port_masks <= cfg_req.wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // Transceiver controls come straight from their fields
  assign phy_ctrl.op_mode = func_ctrl[4:usb_interface_manager_pkg::FUNC_OPMODE_LSB];
  assign phy_ctrl.term_select = func_ctrl[usb_interface_manager_pkg::FUNC_TERM_SELECT];
  assign phy_ctrl.xcvr_select = func_ctrl[usb_interface_manager_pkg::FUNC_XCVR_SELECT];
  assign phy_ctrl.otg_control = otg_ctrl;
  assign phy_ctrl.serial_tx = serial_ctrl;
  assign timing_modes = {control[usb_interface_manager_pkg::CTL_EVENT_ACK_MODE],
                         control[usb_interface_manager_pkg::CTL_POWER_SIGNALLING],
                         control[usb_interface_manager_pkg::CTL_IF_TIMING]};

  // ----------------------------------------------------------------
  // Packet decoder
  // ----------------------------------------------------------------
  logic act_prev;
  logic pkt_start;
  logic pkt_end;
  logic [2:0] byte_cnt;
  logic [7:0] pid_byte;
  logic [7:0] tok_byte1;
  logic [7:0] tok_byte2;
  logic [4:0] crc5;
  logic [15:0] crc16;
  logic pid_good;
  logic is_sof;
  logic tok_ok;
  logic crc_fail;
  logic [3:0] last_pid;
  logic [4:0] last_endpoint;
  // Bit-serial CRC step, LSB of each byte first on the wire
  function automatic logic [4:0] crc5_byte(input logic [4:0] c, input logic [7:0] d);
    logic [4:0] r;
    r = c;
    for (int b = 0; b < 8; b++) begin
      r = {r[3:0], 1'b0} ^ ((d[b] ^ r[4]) ? usb_interface_manager_pkg::CRC5_POLY : 5'h00);
    end
    return r;
  endfunction : crc5_byte

  function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int b = 0; b < 8; b++) begin
      r = {r[14:0], 1'b0} ^ ((d[b] ^ r[15]) ? usb_interface_manager_pkg::CRC16_POLY : 16'h0000);
    end
    return r;
  endfunction : crc16_byte

  assign pkt_start = status_sync.rx_active & ~act_prev;
  assign pkt_end = ~status_sync.rx_active & act_prev;
  assign pid_good = pid_byte[7:4] == ~pid_byte[3:0];
  assign is_sof = pid_byte[3:0] == usb_interface_manager_pkg::PID_FRAME_START;

  // Checking is optional; with it off and token processing on, any well-formed token counts, a frame start token only with its mode bit on
  assign tok_ok = pkt_end && control[usb_interface_manager_pkg::CTL_TOKEN_PROCESSING]
    && pid_good && pid_byte[1:0] == usb_interface_manager_pkg::PID_KIND_TOKEN
    && byte_cnt == usb_interface_manager_pkg::TOKEN_BYTES
    && (!is_sof || control[usb_interface_manager_pkg::CTL_FRAME_START_AS_TOKEN])
    && (!control[usb_interface_manager_pkg::CTL_TOKEN_CHECKING]
        || (crc5 == usb_interface_manager_pkg::CRC5_RESIDUAL
            && (is_sof || tok_byte1[6:0] == dev_addr)));
  assign crc_fail = pkt_end && pid_good
    && pid_byte[1:0] == usb_interface_manager_pkg::PID_KIND_DATA
    && byte_cnt >= usb_interface_manager_pkg::TOKEN_BYTES
    && crc16 != usb_interface_manager_pkg::CRC16_RESIDUAL;
  // Byte capture and running checks over everything after the PID
  always_ff @(posedge ref_clk) begin
    if (state_rst) begin
      act_prev <= 1'b0;
      byte_cnt <= '0;
      pid_byte <= '0;
      tok_byte1 <= '0;
      tok_byte2 <= '0;
      crc5 <= usb_interface_manager_pkg::CRC5_INIT;
      crc16 <= usb_interface_manager_pkg::CRC16_INIT;
    end else begin
      act_prev <= status_sync.rx_active;
      if (pkt_start) begin
        byte_cnt <= '0;
        crc5 <= usb_interface_manager_pkg::CRC5_INIT;
        crc16 <= usb_interface_manager_pkg::CRC16_INIT;
      end else if (status_sync.rx_active && status_sync.rx_valid) begin
        if (byte_cnt != 3'h7) byte_cnt <= byte_cnt + 3'h1;
        if (byte_cnt == 3'h0) begin
          pid_byte <= status_sync.rx_data;
        end else begin
          crc5 <= crc5_byte(crc5, status_sync.rx_data);
          crc16 <= crc16_byte(crc16, status_sync.rx_data);
        end
        if (byte_cnt == 3'h1) tok_byte1 <= status_sync.rx_data;
        if (byte_cnt == 3'h2) tok_byte2 <= status_sync.rx_data;
      end
    end
  end

  // Only tokens that pass decoding are handed on
  always_ff @(posedge ref_clk) begin
    if (state_rst) begin
      last_pid <= '0;
      last_endpoint <= '0;
    end else if (tok_ok) begin
      last_pid <= pid_byte[3:0];
      last_endpoint <= {~is_sof, tok_byte2[2:0], tok_byte1[7]};
    end
  end

  // ----------------------------------------------------------------
  // Signal flags and port lines
  // ----------------------------------------------------------------
  logic [usb_interface_manager_pkg::NUM_FLAGS-1:0] flags;
  logic [usb_interface_manager_pkg::NUM_FLAGS-1:0] flag_event;
  logic line_en;
  assign line_en = control[usb_interface_manager_pkg::CTL_LINE_DECODE];
  assign flag_event = {tok_ok,
    line_en && status_sync.line_state == usb_interface_manager_pkg::LINE_SE0,
    line_en && status_sync.line_state == usb_interface_manager_pkg::LINE_K,
    line_en && status_sync.line_state == usb_interface_manager_pkg::LINE_J,
    crc_fail,
    status_sync.rx_active,
    status_sync.rx_error};

  // Per flag: a set always beats a clear arriving in the same cycle
  for (genvar i = 0; i < usb_interface_manager_pkg::NUM_FLAGS; i++) begin : g_flag
    logic sw_clear;
    assign sw_clear = wr_flags & cfg_req.wdata[i];
    always_ff @(posedge ref_clk) begin
      if (state_rst) begin
        flags[i] <= 1'b0;
      end else if (hold_sel[i]) begin
        flags[i] <= (flags[i] & ~sw_clear) | flag_event[i];
      end else if (i <= usb_interface_manager_pkg::FLAG_RX_ACTIVE) begin
        flags[i] <= flag_event[i];
      end else if (flag_event[i]) begin
        flags[i] <= 1'b1;
      end else if (pkt_start || sw_clear) begin
        flags[i] <= 1'b0;
      end
    end
  end

  // Registered so the lines never glitch on flag updates
  for (genvar p = 0; p < usb_interface_manager_pkg::NUM_PORT_LINES; p++) begin : g_port
    always_ff @(posedge ref_clk) begin
      if (state_rst) begin
        port_lines[p] <= 1'b0;
      end else begin
        port_lines[p] <= |(flags & port_masks[p*8 +: usb_interface_manager_pkg::NUM_FLAGS]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read path
  // ----------------------------------------------------------------
  logic [31:0] next_rdata;
  // Unmapped offsets and reserved bits read as zero
  always_comb begin
    next_rdata = '0;
    unique case (cfg_req.addr)
      usb_interface_manager_pkg::OFF_CONTROL: next_rdata[7:0] = control;
      usb_interface_manager_pkg::OFF_DEVICE_ADDRESS: next_rdata[6:0] = dev_addr;
      usb_interface_manager_pkg::OFF_FUNCTION: next_rdata[4:0] = func_ctrl;
      usb_interface_manager_pkg::OFF_OTG_CONTROL: next_rdata[7:0] = otg_ctrl;
      usb_interface_manager_pkg::OFF_OTG_STATUS: next_rdata[5:0] = status_sync.otg_status;
      usb_interface_manager_pkg::OFF_SERIAL: begin
        next_rdata[6:usb_interface_manager_pkg::SERIAL_RX_LSB] = status_sync.serial_rx;
        next_rdata[3:0] = serial_ctrl;
      end
      usb_interface_manager_pkg::OFF_FLAGS: next_rdata[6:0] = flags;
      usb_interface_manager_pkg::OFF_HOLD_SELECT: next_rdata[6:0] = hold_sel;
      usb_interface_manager_pkg::OFF_PORT_MASKS: next_rdata = port_masks;
      usb_interface_manager_pkg::OFF_PACKET_ID: next_rdata[3:0] = last_pid;
      usb_interface_manager_pkg::OFF_ENDPOINT: next_rdata[4:0] = last_endpoint;
      default: next_rdata = '0;
    endcase
  end

  // One-cycle read answer; software issues only whole-word accesses
  always_ff @(posedge ref_clk) begin
    if (state_rst) begin
      cfg_rdata <= '0;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_req.rd;
      cfg_rdata <= cfg_req.rd ? next_rdata : '0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Write data is taken straight from the bus; sampled one edge back
  property p_soft_reset;
    cfg_req.wr && cfg_req.addr == usb_interface_manager_pkg::OFF_SOFT_RESET
      |-> ##2 control == 8'h00 && dev_addr == 7'h00 && flags == 7'h00 && func_ctrl == 5'h07;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset left state");
  property p_control_write;
    wr_control && !soft_clr |=> control == ($past(cfg_req.wdata[7:0]) & 8'hf7);
  endproperty
  a_control_write: assert property (p_control_write) else $error("control not stored");
  property p_address_write;
    wr_addr && !soft_clr |=> dev_addr == $past(cfg_req.wdata[6:0]);
  endproperty
  a_address_write: assert property (p_address_write) else $error("address not stored");
  property p_opmode_drive;
    wr_func && !soft_clr |=> phy_ctrl.op_mode == $past(cfg_req.wdata[4:2]);
  endproperty
  a_opmode_drive: assert property (p_opmode_drive) else $error("op mode not driven");
  property p_otg_read;
    cfg_req.rd && cfg_req.addr == usb_interface_manager_pkg::OFF_OTG_STATUS && !soft_clr
      |=> cfg_rvalid && cfg_rdata == {26'h0, $past(status_sync.otg_status)};
  endproperty
  a_otg_read: assert property (p_otg_read) else $error("otg status read wrong");
  property p_token_flag;
    tok_ok && !soft_clr |=> flags[usb_interface_manager_pkg::FLAG_NEW_TOKEN];
  endproperty
  a_token_flag: assert property (p_token_flag) else $error("token flag missed");
  property p_se0_flag;
    line_en && status_sync.line_state == 2'h0 && !soft_clr |=> flags[5];
  endproperty
  a_se0_flag: assert property (p_se0_flag) else $error("se0 flag missed");
  property p_crc_flag;
    crc_fail && !soft_clr |=> flags[usb_interface_manager_pkg::FLAG_DATA_CHECK_FAIL];
  endproperty
  a_crc_flag: assert property (p_crc_flag) else $error("crc16 flag missed");
  property p_rx_follow;
    !hold_sel[1] && !soft_clr |=> flags[1] == $past(status_sync.rx_active);
  endproperty
  a_rx_follow: assert property (p_rx_follow) else $error("rx active flag lags");
  property p_hold;
    hold_sel[6] && flags[6] && !(wr_flags && cfg_req.wdata[6]) && !soft_clr |=> flags[6];
  endproperty
  a_hold: assert property (p_hold) else $error("held flag dropped");
  property p_port_line;
    !soft_clr |=> port_lines[0] == |($past(flags) & $past(port_masks[6:0]));
  endproperty
  a_port_line: assert property (p_port_line) else $error("port line wrong");

  c_token: cover property (tok_ok);
  c_crc_fail: cover property (crc_fail);
  c_soft_reset: cover property (soft_clr ##1 control == 8'h00);
  c_held_clear: cover property (hold_sel[6] && flags[6] ##1 !flags[6]);

endmodule : usb_interface_manager

`default_nettype wire
